// ==== core/vc_resource_defines.vh ====
// Offsets, field positions, reset values and timing counts of the channel resource registers
`ifndef VC_RESOURCE_DEFINES_VH
`define VC_RESOURCE_DEFINES_VH

`define VCR_CONTROL_OFFSET   12'h214
`define VCR_STATUS_OFFSET    12'h218
`define VCR_TABLE_LO_OFFSET  12'h220
`define VCR_TABLE_HI_OFFSET  12'h23C

`define TC_MAP_MSB           7
`define TC_MAP_LSB           0
`define TC_MAP_RESET         8'hFF
`define TABLE_LOAD_BIT       16
`define ARB_SEL_MSB          19
`define ARB_SEL_LSB          17
`define ARB_SEL_RESET        3'h0
`define CHANNEL_ID_MSB       26
`define CHANNEL_ID_LSB       24
`define CHANNEL_ID_VALUE     3'h0
`define CHANNEL_EN_BIT       31

`define COHERENCY_BIT        0
`define FLOW_PENDING_BIT     1

`define ARB_CAP_UPSTREAM     8'h03
`define ARB_CAP_DOWNSTREAM   8'h01
`define ARB_SCHEME_WRR32     3'h1

`define TABLE_LOAD_CYCLES    4
`define TABLE_ENTRY_RESET    32'h71765432

`endif

// ==== core/table_load_seq.v ====
// Sequencer that copies the arbitration table into the arbiter and tracks coherency
`include "vc_resource_defines.vh"
module table_load_seq #(
    parameter LOAD_CYCLES = `TABLE_LOAD_CYCLES
) (
    input  wire clock_i,          // Configuration clock
    input  wire sys_rst_i,        // Synchronous reset, active high
    input  wire enable_i,         // Upstream port only
    input  wire table_write_i,    // Software wrote a table entry
    input  wire load_cmd_i,       // One-cycle load command
    output reg  busy_o,           // Load in progress
    output reg  latch_o,          // One-cycle pulse: arbiter takes the table
    output reg  incoherent_o      // Table differs from arbiter copy
);
    // Ranged so that the counter load below is an explicit part-select
    localparam [31:0] LOAD_LAST = LOAD_CYCLES - 1;
    reg [3:0] count;

    // Load runs a fixed number of cycles, then clears the flag unless a new write landed
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            busy_o       <= 1'b0;
            latch_o      <= 1'b0;
            incoherent_o <= 1'b0;
            count        <= 4'h0;
        end else begin
            latch_o <= 1'b0;
            if (load_cmd_i && enable_i && !busy_o) begin
                busy_o <= 1'b1;
                count  <= LOAD_LAST[3:0];
            end else if (busy_o) begin
                if (count == 4'h0) begin
                    busy_o  <= 1'b0;
                    latch_o <= 1'b1;
                end else begin
                    count <= count - 4'h1;
                end
            end
            // Set wins over clear so a write during the finish is not lost
            if (table_write_i && enable_i)
                incoherent_o <= 1'b1;
            else if (busy_o && count == 4'h0)
                incoherent_o <= 1'b0;
        end
    end
endmodule

// ==== core/arb_table_store.v ====
// Arbitration table storage and the arbiter's working copy
`include "vc_resource_defines.vh"
module arb_table_store #(
    parameter ENTRIES = 8
) (
    input  wire        clock_i,      // Configuration clock
    input  wire        sys_rst_i,    // Synchronous reset, active high
    input  wire        wr_i,         // Write strobe to one entry
    input  wire [2:0]  idx_i,        // Entry index
    input  wire [31:0] wdata_i,      // Write data
    input  wire        latch_i,      // Copy table into arbiter
    output wire [31:0] rdata_o,      // Table entry read
    output wire [31:0] active_o      // Arbiter copy of entry 0
);
    wire [31:0] table_w  [0:ENTRIES-1];
    wire [31:0] active_w [0:ENTRIES-1];
    genvar g;

    // One flop pair per entry, each owned by its own slot so no array has two drivers
    generate
        for (g = 0; g < ENTRIES; g = g + 1) begin : entry
            reg [31:0] table_q;
            reg [31:0] active_q;
            always @(posedge clock_i) begin
                if (sys_rst_i) begin
                    table_q  <= `TABLE_ENTRY_RESET;
                    active_q <= `TABLE_ENTRY_RESET;
                end else begin
                    if (wr_i && idx_i == g)
                        table_q <= wdata_i;
                    if (latch_i)
                        active_q <= table_q;
                end
            end
            assign table_w[g]  = table_q;
            assign active_w[g] = active_q;
        end
    endgenerate

    assign rdata_o  = table_w[idx_i];
    assign active_o = active_w[0];
endmodule

// ==== core/vc_resource_ctl_status.v ====
// Control and status registers of the single virtual-channel resource of a switch port
// Functional notes
// - Traffic-class map bits 7:0 reset to all ones; bit 0 read-only.
// - A class is assigned to the channel while its map bit is one.
// - Writing one to bit 16 loads the arbitration table into the arbiter.
// - Writing zero to the load bit does nothing.
// - The load bit always reads zero.
// - The load command acts only in the upstream port.
// - Load is meaningful only under a table-based arbitration scheme.
// - Channel identifier 26:24 is read-only zero.
// - Channel enable bit 31 is read-only one.
// - Coherency status bit 0 sets on any table entry write.
// - Coherency status clears when hardware finishes the requested load.
// - Coherency status reads zero in downstream ports.
// - Status bit 1 reads one while flow-control initialisation is pending.
// - Capability: upstream advertises 0x3, downstream 0x1.
//
// Strobed register access is this design's own decision.
`include "vc_resource_defines.vh"
module vc_resource_ctl_status #(
    parameter UPSTREAM    = 1,
    parameter LOAD_CYCLES = `TABLE_LOAD_CYCLES
) (
    input  wire        clock_i,          // Configuration clock, 25 MHz
    input  wire        sys_rst_i,        // Synchronous reset, active high
    input  wire [11:0] addr_i,           // Byte address
    input  wire [31:0] wdata_i,          // Write data
    input  wire        wr_i,             // Write strobe
    input  wire        rd_i,             // Read strobe
    input  wire        flow_pending_i,   // Flow-control init in progress
    output reg  [31:0] rdata_o,          // Read data, cycle after strobe
    output reg  [7:0]  tc_assigned_o,    // Classes mapped to the channel
    output reg  [2:0]  arb_select_o,     // Selected arbitration scheme
    output reg  [7:0]  arb_capability_o, // Advertised capability
    output reg         load_busy_o,      // Table load running
    output reg  [31:0] arb_active_o      // Arbiter copy of first entry
);
    localparam [7:0] CAPABILITY = (UPSTREAM != 0) ? `ARB_CAP_UPSTREAM : `ARB_CAP_DOWNSTREAM;
    localparam       IS_UP      = (UPSTREAM != 0) ? 1'b1 : 1'b0;

    reg  [6:0]  tc_map_hi;
    reg  [2:0]  arb_select;
    reg         flow_pending;
    reg         load_cmd;
    wire        busy;
    wire        latch;
    wire        incoherent;
    wire [31:0] table_rdata;
    wire [31:0] active_entry;
    wire        sel_ctl;
    wire        sel_sts;
    wire        sel_tbl;
    wire        table_write;
    wire        table_based;
    reg  [31:0] next_rdata;

    assign sel_ctl     = (addr_i == `VCR_CONTROL_OFFSET);
    assign sel_sts     = (addr_i == `VCR_STATUS_OFFSET);
    assign sel_tbl     = (addr_i >= `VCR_TABLE_LO_OFFSET) && (addr_i <= `VCR_TABLE_HI_OFFSET)
                         && (addr_i[1:0] == 2'b00);
    // Downstream ports have no table, so writes there fall away
    assign table_write = wr_i && sel_tbl && IS_UP;
    // Only the weighted scheme consumes the table
    assign table_based = (arb_select == `ARB_SCHEME_WRR32);

    // Control register writes; reserved and read-only fields take nothing
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            tc_map_hi    <= 7'h7F;
            arb_select   <= `ARB_SEL_RESET;
            load_cmd     <= 1'b0;
            flow_pending <= 1'b0;
        end else begin
            flow_pending <= flow_pending_i;
            load_cmd     <= 1'b0;
            if (wr_i && sel_ctl) begin
                tc_map_hi  <= wdata_i[`TC_MAP_MSB:`TC_MAP_LSB+1];
                arb_select <= wdata_i[`ARB_SEL_MSB:`ARB_SEL_LSB];
                // A zero in the load bit starts no load; downstream ignores it
                load_cmd   <= wdata_i[`TABLE_LOAD_BIT] && IS_UP && table_based;
            end
        end
    end

    table_load_seq #(
        .LOAD_CYCLES (LOAD_CYCLES)
    ) u_seq (
        .clock_i      (clock_i),
        .sys_rst_i    (sys_rst_i),
        .enable_i     (IS_UP),
        .table_write_i(table_write),
        .load_cmd_i   (load_cmd),
        .busy_o       (busy),
        .latch_o      (latch),
        .incoherent_o (incoherent)
    );

    arb_table_store #(
        .ENTRIES (8)
    ) u_table (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .wr_i      (table_write),
        .idx_i     (addr_i[4:2]),
        .wdata_i   (wdata_i),
        .latch_i   (latch),
        .rdata_o   (table_rdata),
        .active_o  (active_entry)
    );

    // Read mux; unmapped addresses and reserved bits answer zero
    always @* begin
        next_rdata = 32'h00000000;
        if (sel_ctl) begin
            next_rdata[`TC_MAP_MSB:`TC_MAP_LSB]         = {tc_map_hi, 1'b1};
            next_rdata[`TABLE_LOAD_BIT]                 = 1'b0;
            next_rdata[`ARB_SEL_MSB:`ARB_SEL_LSB]       = arb_select;
            next_rdata[`CHANNEL_ID_MSB:`CHANNEL_ID_LSB] = `CHANNEL_ID_VALUE;
            next_rdata[`CHANNEL_EN_BIT]                 = 1'b1;
        end else if (sel_sts) begin
            next_rdata[`COHERENCY_BIT]    = incoherent && IS_UP;
            next_rdata[`FLOW_PENDING_BIT] = flow_pending;
        end else if (sel_tbl && IS_UP) begin
            next_rdata = table_rdata;
        end
    end

    // Registered outputs
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            rdata_o          <= 32'h00000000;
            tc_assigned_o    <= `TC_MAP_RESET;
            arb_select_o     <= `ARB_SEL_RESET;
            arb_capability_o <= 8'h00;
            load_busy_o      <= 1'b0;
            arb_active_o     <= 32'h00000000;
        end else begin
            rdata_o          <= rd_i ? next_rdata : 32'h00000000;
            tc_assigned_o    <= {tc_map_hi, 1'b1};
            arb_select_o     <= arb_select;
            arb_capability_o <= CAPABILITY;
            load_busy_o      <= busy;
            arb_active_o     <= active_entry;
        end
    end
endmodule

// ==== dv/vc_resource_assertions.sv ====
// Port-level checks of the channel resource registers
`include "vc_resource_defines.vh"
module vc_resource_checker #(
    parameter UPSTREAM    = 1,
    parameter LOAD_CYCLES = 4
) (
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic        flow_pending_i,
    input wire logic [31:0] rdata_o,
    input wire logic [7:0]  tc_assigned_o,
    input wire logic [2:0]  arb_select_o,
    input wire logic [7:0]  arb_capability_o,
    input wire logic        load_busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // Decoded accesses; a load request is only legal while idle
    wire ctl_wr = wr_i && addr_i == `VCR_CONTROL_OFFSET;
    wire ctl_rd = rd_i && addr_i == `VCR_CONTROL_OFFSET;
    wire sts_rd = rd_i && addr_i == `VCR_STATUS_OFFSET;
    wire go     = ctl_wr && wdata_i[`TABLE_LOAD_BIT] && !load_busy_o;
    a_map_low_fixed: assert property (tc_assigned_o[0]) else $error("map bit 0 low");
    a_map_follows_write: assert property (ctl_wr |-> ##2 tc_assigned_o == {$past(wdata_i[7:1], 2), 1'b1})
        else $error("map not stored");
    a_ctl_fixed_bits: assert property ($past(ctl_rd) |-> rdata_o[31] && rdata_o[30:20] == 11'h000
        && rdata_o[16:8] == 9'h000) else $error("control fixed bits wrong");
    a_status_read_bits: assert property ($past(sts_rd) |-> rdata_o[31:2] == 30'h0
        && rdata_o[1] == $past(flow_pending_i, 2)) else $error("status bits wrong");
    a_load_starts: assert property (UPSTREAM != 0 && go && arb_select_o == `ARB_SCHEME_WRR32 |-> ##[1:4] load_busy_o)
        else $error("load did not start");
    a_zero_no_load: assert property (ctl_wr && !wdata_i[16] && !load_busy_o |-> !load_busy_o[*4])
        else $error("zero write started load");
    a_scheme_gate: assert property (go && arb_select_o != `ARB_SCHEME_WRR32 |-> !load_busy_o[*4])
        else $error("load under wrong scheme");
    a_busy_bounded: assert property ($rose(load_busy_o) |-> load_busy_o[*4] ##1 !load_busy_o)
        else $error("load length wrong");
    a_cap_fixed: assert property (!$past(sys_rst_i) |-> arb_capability_o ==
        (UPSTREAM ? `ARB_CAP_UPSTREAM : `ARB_CAP_DOWNSTREAM)) else $error("capability wrong");
    c_load_done: cover property ($fell(load_busy_o));
    c_gated_load: cover property (go && arb_select_o == 3'h0);
    c_status_set: cover property ($past(sts_rd) && rdata_o[0]);
endmodule

// ==== dv/tb_vc_resource_ctl_status.sv ====
// Self-checking bench for the channel resource registers
`include "vc_resource_defines.vh"
module tb_vc_resource_ctl_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [11:0] addr_i = 12'h000;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        flow_pending_i = 1'b0;
    logic [31:0] rdata_o;
    logic [31:0] arb_active_o;
    logic [7:0]  tc_assigned_o;
    logic [7:0]  arb_capability_o;
    logic [2:0]  arb_select_o;
    logic        load_busy_o;
    logic [31:0] dn_rdata;
    logic [31:0] dn_active;
    logic [7:0]  dn_capability;
    logic        dn_busy;
    int          n_mismatch = 0;
    int          total_checks = 0;
    localparam logic [11:0] CTL = `VCR_CONTROL_OFFSET;
    localparam logic [11:0] STS = `VCR_STATUS_OFFSET;
    always #20 clock_i = ~clock_i;
    vc_resource_ctl_status vc_resource_ctl_status_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .flow_pending_i(flow_pending_i), .rdata_o(rdata_o),
        .tc_assigned_o(tc_assigned_o), .arb_select_o(arb_select_o), .arb_capability_o(arb_capability_o),
        .load_busy_o(load_busy_o), .arb_active_o(arb_active_o));
    // Downstream copy on the same stimulus: no table, no load, reduced capability
    vc_resource_ctl_status #(.UPSTREAM(0)) vc_resource_ctl_status_dn_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .flow_pending_i(flow_pending_i),
        .rdata_o(dn_rdata), .tc_assigned_o(), .arb_select_o(), .arb_capability_o(dn_capability),
        .load_busy_o(dn_busy), .arb_active_o(dn_active));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle strobes, launched just after an edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask
    // Bounded wait, so a stuck load cannot hang the run
    task automatic wait_busy(input logic lvl);
        int k;
        for (k = 0; k < 20 && load_busy_o !== lvl; k++) begin
            @(posedge clock_i);
            #1;
        end
        if (load_busy_o !== lvl) begin
            n_mismatch++;
            give_verdict();
        end
    endtask
    task automatic no_busy();
        repeat (8) begin
            @(posedge clock_i);
            #1 chk(load_busy_o, 32'h0);
        end
    endtask
    task automatic s_reset_values();
        rd(CTL, 32'h800000FF);
        rd(STS, 32'h0);
        chk(dn_rdata, 32'h0);
        chk(dn_capability, 32'h1);
        chk(arb_capability_o, 32'h3);
        chk(tc_assigned_o, 32'hFF);
    endtask
    task automatic s_fields();
        wr(CTL, 32'h7FF2FF00);
        rd(CTL, 32'h80020001);
        chk(tc_assigned_o, 32'h01);
        chk(arb_select_o, 32'h1);
        no_busy();
    endtask
    task automatic s_load();
        wr(12'h220, 32'hA5A5A5A5);
        rd(STS, 32'h1);
        chk(dn_rdata, 32'h0);
        wr(CTL, 32'h00030001);
        rd(STS, 32'h1);
        wait_busy(1'b1);
        chk(dn_busy, 32'h0);
        wait_busy(1'b0);
        rd(STS, 32'h0);
        chk(arb_active_o, 32'hA5A5A5A5);
        chk(dn_active, `TABLE_ENTRY_RESET);
        rd(12'h220, 32'hA5A5A5A5);
        chk(dn_rdata, 32'h0);
        rd(CTL, 32'h80020001);
    endtask
    // Load under the fixed scheme must leave the arbiter copy alone
    task automatic s_wrong_scheme();
        wr(CTL, 32'h00000001);
        wr(12'h220, 32'h12345678);
        wr(CTL, 32'h00010001);
        no_busy();
        rd(STS, 32'h1);
        chk(arb_active_o, 32'hA5A5A5A5);
    endtask
    task automatic s_flow_unmapped();
        @(posedge clock_i);
        flow_pending_i <= 1'b1;
        rd(STS, 32'h3);
        wr(12'h300, 32'hFFFFFFFF);
        rd(12'h300, 32'h0);
        rd(CTL, 32'h80000001);
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        s_reset_values();
        s_fields();
        s_load();
        s_wrong_scheme();
        s_flow_unmapped();
        give_verdict();
    end
endmodule
bind vc_resource_ctl_status vc_resource_checker #(.UPSTREAM(UPSTREAM), .LOAD_CYCLES(LOAD_CYCLES)) checker_i (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .flow_pending_i(flow_pending_i), .rdata_o(rdata_o), .tc_assigned_o(tc_assigned_o),
    .arb_select_o(arb_select_o), .arb_capability_o(arb_capability_o), .load_busy_o(load_busy_o));
